// file: fault_indicator.sv
`timescale 1ns/1ps
module fault_indicator #(
  parameter int     MS_CYCLES    = fault_pkg::MS_CYCLES,
  parameter longint SUSP_MS      = fault_pkg::SUSP_YEAR_MS
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [1:0]  safe_input_one,
  input  wire logic [1:0]  safe_input_two,
  input  wire logic [7:0]  disc_ms_one,
  input  wire logic [7:0]  disc_ms_two,
  input  wire logic        sf_state_one,
  input  wire logic        sf_state_two,
  input  wire logic        safely_limited_speed,
  input  wire logic        speed_below_thr,
  input  wire logic [15:0] zero_speed_ms,
  input  wire logic        fb_sf_activate,
  input  wire logic [1:0]  reaction_sel,
  input  wire logic        limit_fail_a,
  input  wire logic        limit_fail_b,
  input  wire logic        general_fail,
  input  wire logic        ack,
  output logic [7:0]       fault_code,
  output logic             safe_torque_off,
  output logic             safe_stop_variant_a,
  output logic             safe_stop_variant_b,
  output logic             led_one_red,
  output logic             led_one_green,
  output logic             led_two_red,
  output logic             led_two_green,
  output logic             fault_led_red,
  output logic             fault_led_green
);

  typedef struct packed {
    logic [3:0]             meta;
    logic [3:0]             sync;
    logic [1:0][15:0]       disc;
    logic [15:0]            zero;
    logic [35:0]            susp;
    fault_pkg::fault_state_e st;
    logic [7:0]             code;
    logic [1:0]             react;
  } ind_s;

  ind_s s_q;
  ind_s s_d;
  logic ms_tick;
  logic blink_on;

  ms_ticker #(
    .MS_CYCLES (MS_CYCLES)
  ) u_ticker (
    .clk      (clk),
    .rst_b    (rst_b),
    .ms_tick  (ms_tick),
    .blink_on (blink_on)
  );

  function automatic logic [7:0] ext_code(input logic [1:0] r,
                                          input logic [7:0] kind);
    case (r)
      fault_pkg::REACT_SSA: ext_code = fault_pkg::CODE_EXT_SSA + kind;
      fault_pkg::REACT_SSB: ext_code = fault_pkg::CODE_EXT_SSB + kind;
      default:              ext_code = fault_pkg::CODE_EXT_STO + kind;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Detection

  logic       in_bad [2];
  logic       zero_bad;
  logic       susp_bad;
  logic       lim_ssb;
  logic       ext_ev;
  logic [7:0] ext_kind;

  always_comb begin
    in_bad[0] = s_q.disc[0] > {8'h00, disc_ms_one};
    in_bad[1] = s_q.disc[1] > {8'h00, disc_ms_two};
    zero_bad  = s_q.zero > zero_speed_ms;
    susp_bad  = fb_sf_activate && (36'(SUSP_MS) < s_q.susp);
    lim_ssb   = reaction_sel == fault_pkg::REACT_SSB;
    ext_ev    = in_bad[0] || in_bad[1] || zero_bad || susp_bad;
    if (in_bad[0]) begin
      ext_kind = fault_pkg::EXT_IN_ONE;
    end else if (in_bad[1]) begin
      ext_kind = fault_pkg::EXT_IN_TWO;
    end else if (zero_bad) begin
      ext_kind = fault_pkg::EXT_ZERO;
    end else begin
      ext_kind = fault_pkg::EXT_SUSP;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d      = s_q;
    s_d.meta = {safe_input_two, safe_input_one};
    s_d.sync = s_q.meta;
    if (ms_tick) begin
      for (int i = 0; i < 2; i++) begin
        // Channels must agree within the configured discrepancy time
        if (s_q.sync[2*i] != s_q.sync[2*i+1]) begin
          if (s_q.disc[i] != 16'hFFFF) begin
            s_d.disc[i] = s_q.disc[i] + 16'h0001;
          end
        end else begin
          s_d.disc[i] = 16'h0000;
        end
      end
      if (safely_limited_speed && speed_below_thr) begin
        if (s_q.zero != 16'hFFFF) begin
          s_d.zero = s_q.zero + 16'h0001;
        end
      end else begin
        s_d.zero = 16'h0000;
      end
      if (speed_below_thr) begin
        if (s_q.susp != '1) begin
          s_d.susp = s_q.susp + 36'h000000001;
        end
      end else begin
        s_d.susp = '0;
      end
    end
    case (s_q.st)
      fault_pkg::ST_IDLE: begin
        if (limit_fail_a || limit_fail_b) begin
          s_d.st    = fault_pkg::ST_INT;
          s_d.react = lim_ssb ? fault_pkg::REACT_SSB : fault_pkg::REACT_SSA;
          if (limit_fail_a) begin
            s_d.code = lim_ssb ? fault_pkg::CODE_LIM_A_SSB
                               : fault_pkg::CODE_LIM_A_SSA;
          end else begin
            s_d.code = lim_ssb ? fault_pkg::CODE_LIM_B_SSB
                               : fault_pkg::CODE_LIM_B_SSA;
          end
        end else if (ext_ev) begin
          s_d.st    = fault_pkg::ST_EXT;
          // The spare select code stops by torque off, matching its code
          s_d.react = (reaction_sel == fault_pkg::REACT_SSA
                       || reaction_sel == fault_pkg::REACT_SSB)
                      ? reaction_sel : fault_pkg::REACT_STO;
          s_d.code  = ext_code(reaction_sel,
                               ext_kind);
        end
      end
      // A cause still present after acknowledge relatches a cycle later
      fault_pkg::ST_EXT, fault_pkg::ST_INT: begin
        if (ack) begin
          s_d.st   = fault_pkg::ST_IDLE;
          s_d.code = fault_pkg::CODE_NONE;
        end
      end
      fault_pkg::ST_FATAL: begin
        s_d.st = fault_pkg::ST_FATAL;
      end
      default: begin
        s_d.st = fault_pkg::ST_IDLE;
      end
    endcase
    // General failure overrides anything and ignores acknowledge
    if (general_fail) begin
      s_d.st    = fault_pkg::ST_FATAL;
      s_d.code  = fault_pkg::CODE_GENERAL;
      s_d.react = fault_pkg::REACT_STO;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q      <= '0;
      s_q.st   <= fault_pkg::ST_IDLE;
      s_q.code <= fault_pkg::CODE_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  logic idle;
  logic one_flt;
  logic two_flt;

  always_comb begin
    idle    = s_q.st == fault_pkg::ST_IDLE;
    one_flt = s_q.st == fault_pkg::ST_EXT
              && (s_q.code == fault_pkg::CODE_EXT_STO
                  || s_q.code == fault_pkg::CODE_EXT_SSA
                  || s_q.code == fault_pkg::CODE_EXT_SSB);
    two_flt = s_q.st == fault_pkg::ST_EXT
              && (s_q.code == fault_pkg::CODE_EXT_STO + 8'h01
                  || s_q.code == fault_pkg::CODE_EXT_SSA + 8'h01
                  || s_q.code == fault_pkg::CODE_EXT_SSB + 8'h01);
  end

  assign fault_code          = s_q.code;
  assign safe_torque_off     = !idle && s_q.react == fault_pkg::REACT_STO;
  assign safe_stop_variant_a = !idle && s_q.react == fault_pkg::REACT_SSA;
  assign safe_stop_variant_b = !idle && s_q.react == fault_pkg::REACT_SSB;
  assign led_one_red         = one_flt || sf_state_one;
  assign led_one_green       = !one_flt && !sf_state_one;
  assign led_two_red         = two_flt || sf_state_two;
  assign led_two_green       = !two_flt && !sf_state_two;
  assign fault_led_red       = (s_q.st == fault_pkg::ST_EXT) ? blink_on
                               : !idle;
  assign fault_led_green     = idle;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_fatal_sticky: assert property (
    s_q.st == fault_pkg::ST_FATAL |=> fault_code == fault_pkg::CODE_GENERAL)
    else $error("general failure code left without reset");
  chk_general_code: assert property (
    general_fail |=> fault_code == 8'hFC && safe_torque_off)
    else $error("general failure not reported as 252");
  chk_latch_hold: assert property (
    !idle && !ack && !general_fail |=> $stable(fault_code))
    else $error("fault code changed without acknowledge");
  chk_int_led_red: assert property (
    s_q.st == fault_pkg::ST_INT |-> fault_led_red && !fault_led_green)
    else $error("internal fault led not red constant");
  chk_ext_flash: assert property (
    s_q.st == fault_pkg::ST_EXT |-> fault_led_red == blink_on)
    else $error("external fault led not flashing");
  chk_led_two_red: assert property (
    fault_code == 8'hB2 && s_q.st == fault_pkg::ST_EXT |-> led_two_red)
    else $error("input two fault without red led two");
  chk_in_one_code: assert property (
    idle && !limit_fail_a && !limit_fail_b && !general_fail && in_bad[0]
    && reaction_sel == 2'h0 |=> fault_code == 8'h71)
    else $error("input one torque-off fault not 113");
  chk_in_one_ssb: assert property (
    idle && !limit_fail_a && !limit_fail_b && !general_fail && in_bad[0]
    && reaction_sel == 2'h2 |=> fault_code == 8'hF1 && led_one_red)
    else $error("input one variant-b fault not 241");
  chk_zero_code: assert property (
    idle && !limit_fail_a && !limit_fail_b && !general_fail && zero_bad
    && !in_bad[0] && !in_bad[1] && reaction_sel == 2'h1
    |=> fault_code == 8'hB3)
    else $error("zero-speed timer fault not 179");
  chk_lim_b_code: assert property (
    idle && !limit_fail_a && limit_fail_b && !general_fail
    && reaction_sel == 2'h2 |=> fault_code == 8'hC7)
    else $error("limit b variant-b fault not 199");

endmodule

// file: fault_pkg.sv
// How it works
// - Input one illegal: code 177 or 241
// - Input one illegal, torque off: code 113
// - Input two illegal: codes 114, 178, 242
// - Input two fault: LED two red constant
// - Input one fault: LED one red constant
// - Low speed beyond zero-speed time: 115/179/243
// - Year-long suspension then activation: 116/180/244
// - Speed-limit internal faults 134/135/198/199, red
// - Code 252 cleared only by power cycle
// - Discrepancy time is configurable per input
package fault_pkg;

  // Clock and timing
  localparam int CLK_HZ         = 50_000_000;
  localparam int TICK_MS        = 1;
  localparam int MS_CYCLES      = CLK_HZ / 1000 * TICK_MS;
  localparam int BLINK_HALF_MS  = 500;
  localparam longint SUSP_YEAR_MS = 64'd31536000000;
  localparam int SPEED_LOW_RPM  = 120;

  // Reaction select encoding
  localparam logic [1:0] REACT_STO = 2'h0;
  localparam logic [1:0] REACT_SSA = 2'h1;
  localparam logic [1:0] REACT_SSB = 2'h2;

  // Error codes
  localparam logic [7:0] CODE_NONE      = 8'h00;
  localparam logic [7:0] CODE_EXT_STO   = 8'h71;  // 113
  localparam logic [7:0] CODE_EXT_SSA   = 8'hB1;  // 177
  localparam logic [7:0] CODE_EXT_SSB   = 8'hF1;  // 241
  localparam logic [7:0] CODE_LIM_A_SSA = 8'h86;  // 134
  localparam logic [7:0] CODE_LIM_B_SSA = 8'h87;  // 135
  localparam logic [7:0] CODE_LIM_A_SSB = 8'hC6;  // 198
  localparam logic [7:0] CODE_LIM_B_SSB = 8'hC7;  // 199
  localparam logic [7:0] CODE_GENERAL   = 8'hFC;  // 252

  // External failure kinds, offset from the reaction base code
  localparam logic [7:0] EXT_IN_ONE = 8'h00;
  localparam logic [7:0] EXT_IN_TWO = 8'h01;
  localparam logic [7:0] EXT_ZERO   = 8'h02;
  localparam logic [7:0] EXT_SUSP   = 8'h03;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_EXT   = 4'h2,
    ST_INT   = 4'h4,
    ST_FATAL = 4'h8
  } fault_state_e;

endpackage

// file: ms_ticker.sv
`timescale 1ns/1ps
module ms_ticker #(
  parameter int MS_CYCLES = fault_pkg::MS_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_b,
  output logic      ms_tick,
  output logic      blink_on
);

  typedef struct packed {
    logic [15:0] div;
    logic [9:0]  half;
    logic        tick;
    logic        blink;
  } tick_s;

  tick_s s_q;
  tick_s s_d;

  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (s_q.div == 16'(MS_CYCLES - 1)) begin
      s_d.div  = 16'h0000;
      s_d.tick = 1'b1;
      // Flash cycle of 500 ms on, 500 ms off
      if (s_q.half == 10'(fault_pkg::BLINK_HALF_MS - 1)) begin
        s_d.half  = 10'h000;
        s_d.blink = ~s_q.blink;
      end else begin
        s_d.half = s_q.half + 10'h001;
      end
    end else begin
      s_d.div = s_q.div + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ms_tick  = s_q.tick;
  assign blink_on = s_q.blink;

endmodule

// file: sensor_model.sv
`timescale 1ns/1ps
module sensor_model (
  input  wire logic       clk,
  input  wire logic [1:0] demand,
  input  wire logic [1:0] stuck,
  output logic      [1:0] pins_one,
  output logic      [1:0] pins_two
);
  initial begin
    pins_one = 2'h0;
    pins_two = 2'h0;
  end
  // Broken sensor: second channel stuck low, so the pair disagrees
  always @(negedge clk) begin
    pins_one <= {demand[0] & ~stuck[0], demand[0]};
    pins_two <= {demand[1] & ~stuck[1], demand[1]};
  end
endmodule

// file: fault_indicator_tb_top.sv
`timescale 1ns/1ps
module fault_indicator_tb_top;
  localparam int MSC = 10;
  logic        clk, rst_b, ack, fb_sf_activate, general_fail;
  logic        sf_state_one, sf_state_two, safely_limited_speed;
  logic        speed_below_thr, limit_fail_a, limit_fail_b;
  logic        safe_torque_off, safe_stop_variant_a, safe_stop_variant_b;
  logic        led_one_red, led_one_green, led_two_red, led_two_green;
  logic        fault_led_red, fault_led_green;
  logic [1:0]  reaction_sel, stuck, pins_one, pins_two;
  logic [7:0]  disc_ms_one, disc_ms_two, fault_code, exp;
  logic [15:0] zero_speed_ms;
  int          n_errors, check_count, n, d, ones;

  sensor_model sensor_model_inst (.clk(clk), .demand(2'h3), .stuck(stuck),
    .pins_one(pins_one), .pins_two(pins_two));

  fault_indicator #(.MS_CYCLES(MSC), .SUSP_MS(5)) fault_indicator_inst (
    .clk(clk), .rst_b(rst_b), .safe_input_one(pins_one),
    .safe_input_two(pins_two), .disc_ms_one(disc_ms_one),
    .disc_ms_two(disc_ms_two), .sf_state_one(sf_state_one),
    .sf_state_two(sf_state_two), .safely_limited_speed(safely_limited_speed),
    .speed_below_thr(speed_below_thr), .zero_speed_ms(zero_speed_ms),
    .fb_sf_activate(fb_sf_activate), .reaction_sel(reaction_sel),
    .limit_fail_a(limit_fail_a), .limit_fail_b(limit_fail_b),
    .general_fail(general_fail), .ack(ack), .fault_code(fault_code),
    .safe_torque_off(safe_torque_off),
    .safe_stop_variant_a(safe_stop_variant_a),
    .safe_stop_variant_b(safe_stop_variant_b),
    .led_one_red(led_one_red), .led_one_green(led_one_green),
    .led_two_red(led_two_red), .led_two_green(led_two_green),
    .fault_led_red(fault_led_red), .fault_led_green(fault_led_green));

  initial clk = 1'b0;
  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic err(input string m);
    n_errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e,
                     input string m);
    check_count++;
    if (g !== e) begin
      err($sformatf("%s got %0d want %0d", m, g, e));
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] ext_code(input int s, input int k);
    logic [7:0] b;
    b = (s == 1) ? 8'hB1 : (s == 2) ? 8'hF1 : 8'h71;
    return b + k[7:0];
  endfunction

  // Reaction follows the code's top two bits: 01 off, 10 stop a, 11 stop b
  task automatic chk_react(input logic [7:0] c);
    chk({safe_torque_off, safe_stop_variant_a, safe_stop_variant_b},
        {c[7:6] == 2'h1, c[7:6] == 2'h2, c[7:6] == 2'h3}, "reaction");
  endtask

  task automatic wait_code(input int lim);
    n = 0;
    while (fault_code === 8'h00 && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (fault_code === 8'h00) err("no fault raised");
  endtask

  task automatic do_ack();
    ack = 1'b1;
    @(negedge clk);
    ack = 1'b0;
    @(negedge clk);
    chk(fault_code, 8'h00, "code after ack");
    chk(fault_led_green, 1'b1, "green idle");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    // About 11,000 cycles are expected; allow a little under three times
    #600_000;
    err("watchdog");
    end_of_test();
  end

  initial begin
    {rst_b, ack, fb_sf_activate, general_fail, limit_fail_a} = 5'h00;
    {limit_fail_b, safely_limited_speed, speed_below_thr} = 3'h0;
    {sf_state_one, sf_state_two, reaction_sel, stuck} = 6'h00;
    {disc_ms_one, disc_ms_two, zero_speed_ms} = 32'h0303_0004;
    n_errors = 0;
    check_count = 0;
    void'($urandom(73808));
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    sf_state_one = 1'($urandom);
    @(negedge clk);
    chk(fault_code, 8'h00, "reset code");
    chk({fault_led_red, fault_led_green}, 2'h1, "reset led");
    chk(led_one_red, sf_state_one, "led one follows");
    chk(led_one_green, !sf_state_one, "led one green");
    $display("test reset done");
    for (int s = 0; s < 3; s++) for (int k = 0; k < 2; k++) begin
      reaction_sel = s[1:0];
      {limit_fail_b, limit_fail_a} = k ? 2'h2 : 2'h1;
      @(negedge clk);
      {limit_fail_b, limit_fail_a} = 2'h0;
      exp = ((s == 2) ? 8'hC6 : 8'h86) + k[7:0];
      chk(fault_code, exp, "limit code");
      chk(fault_led_red, 1'b1, "red steady");
      chk_react(exp);
      limit_fail_a = 1'b1;
      repeat (3) @(negedge clk);
      limit_fail_a = 1'b0;
      chk(fault_code, exp, "event refused");
      do_ack();
    end
    $display("test limit done");
    disc_ms_two = 8'hFF;
    stuck = 2'h2;
    repeat (150) @(negedge clk);
    stuck = 2'h0;
    chk(fault_code, 8'h00, "long discrepancy allowed");
    // Counters clear only on a ms tick, so let one pass
    repeat (2 * MSC) @(negedge clk);
    for (int i = 0; i < 2; i++) for (int s = 0; s < 4; s++) begin
      reaction_sel = s[1:0];
      {sf_state_one, sf_state_two} = 2'($urandom);
      d = $urandom_range(1, 5);
      disc_ms_one = d[7:0];
      disc_ms_two = d[7:0];
      stuck[i] = 1'b1;
      wait_code(200);
      if (n < d * MSC) err("fault too early");
      exp = ext_code(s, i);
      chk(fault_code, exp, "pin code");
      chk_react(exp);
      chk(i ? led_two_red : led_one_red, 1'b1,
          "led red");
      chk(i ? led_one_red : led_two_red,
          i ? sf_state_one : sf_state_two, "other led");
      chk(led_two_green, i ? 1'b0 : !sf_state_two,
          "led two green");
      stuck[i] = 1'b0;
      if (i == 0 && s == 0) begin
        ones = 0;
        repeat (10000) begin
          @(negedge clk);
          ones += fault_led_red;
        end
        if (ones < 4999 || ones > 5001) err("blink period");
        chk(fault_code, exp, "still latched");
      end
      repeat (2 * MSC) @(negedge clk);
      do_ack();
    end
    $display("test pins done");
    reaction_sel = 2'($urandom_range(0, 2));
    d = $urandom_range(2, 8);
    zero_speed_ms = d[15:0];
    {safely_limited_speed, speed_below_thr} = 2'h3;
    wait_code((d + 3) * MSC);
    if (n < d * MSC) err("zero speed too early");
    chk(fault_code, ext_code(reaction_sel, 2), "zero code");
    {safely_limited_speed, speed_below_thr} = 2'h0;
    repeat (MSC) @(negedge clk);
    do_ack();
    $display("test zero speed done");
    speed_below_thr = 1'b1;
    for (int t = 2; t < 12; t += 8) begin
      repeat (t * MSC) @(negedge clk);
      fb_sf_activate = 1'b1;
      @(negedge clk);
      fb_sf_activate = 1'b0;
      repeat (2) @(negedge clk);
      exp = (t == 2) ? 8'h00 : ext_code(reaction_sel, 3);
      chk(fault_code, exp, "suspension code");
    end
    speed_below_thr = 1'b0;
    do_ack();
    $display("test suspension done");
    general_fail = 1'b1;
    @(negedge clk);
    general_fail = 1'b0;
    ack = 1'b1;
    limit_fail_a = 1'b1;
    repeat (3) @(negedge clk);
    {ack, limit_fail_a} = 2'h0;
    chk(fault_code, 8'hFC, "general held");
    chk(fault_led_red, 1'b1, "general red");
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    chk(fault_code, 8'h00, "power cycle clears");
    $display("test general done");
    end_of_test();
  end
endmodule
